// ### verilog/pic_defines.svh
// Constants for the priority interrupt controller: register offsets,
// field positions, source numbers and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (8-bit address space)
// ----------------------------------------------------------------
`define PIC_OFS_ENABLE_LO 8'h00
`define PIC_OFS_ENABLE_HI 8'h01
`define PIC_OFS_PRIO_LO 8'h02
`define PIC_OFS_PRIO_HI 8'h03
`define PIC_OFS_CTRL 8'h04
`define PIC_OFS_FLAG_LO 8'h05
`define PIC_OFS_FLAG_HI 8'h06
`define PIC_OFS_STATUS 8'h07
`define PIC_OFS_EVT 8'h08
`define PIC_OFS_EVT_MASK 8'h09
`define PIC_OFS_WB_INDEX 8'h0A
`define PIC_OFS_WB_VALUE 8'h0B

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PIC_CTRL_GIE 0
`define PIC_CTRL_PFE 1
`define PIC_CTRL_IT0 2
`define PIC_CTRL_IT1 3

// ----------------------------------------------------------------
// Wire bus master internal register indexes
// ----------------------------------------------------------------
`define PIC_WB_IDX_ENABLE 3'h0
`define PIC_WB_IDX_FLAGS 3'h1
`define PIC_WB_GIE_BIT 7

// ----------------------------------------------------------------
// Source numbers (natural priority)
// ----------------------------------------------------------------
`define PIC_SRC_PF 0
`define PIC_SRC_EXT0 1
`define PIC_SRC_TMR0 2
`define PIC_SRC_EXT1 3
`define PIC_SRC_TMR1 4
`define PIC_SRC_GRP 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIC_RST_BYTE 8'h00
`define PIC_RST_VEC 8'h00

`endif

// ### verilog/pic_pkg.sv
// Types shared by the priority interrupt controller files.
// Assumes pic_defines.svh holds the numeric constants.
package pic_pkg;
  // Service level of the routine currently running
  typedef enum logic [1:0] {PIC_LVL_NONE, PIC_LVL_LOW, PIC_LVL_HIGH, PIC_LVL_TOP} pic_level_e;
  // One bit per source
  typedef logic [15:0] pic_src_t;
  // Vector address
  typedef logic [7:0] pic_vec_t;
endpackage : pic_pkg

// ### verilog/pic_wirebus_irq.sv
// Wire bus master interrupt block: internal enable and flag registers,
// reached only through an index/value register pair.
// Assumes the caller decodes the two port registers.
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_wirebus_irq
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus master event sources
  input wire logic [6:0] evt,
  // Index/value port access
  input wire logic idx_wr,
  input wire logic val_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] val_rd,
  // Merged request out and global enable
  output logic request,
  output logic wb_enable
);
  import pic_pkg::*;

  // Selected internal register
  logic [2:0] index_q;
  // Enable register: global enable in bit 7
  logic [7:0] enable_q;
  // Per-source flags
  logic [6:0] flags_q;

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      index_q <= 3'h0;
    else if (idx_wr)
      index_q <= wdata[2:0];
  end

  // Enable register, written only indirectly
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      enable_q <= `PIC_RST_BYTE;
    else if (val_wr && index_q == `PIC_WB_IDX_ENABLE)
      enable_q <= wdata;
  end

  // Flags: set wins over write-one-to-clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_q <= 7'h00;
    else if (val_wr && index_q == `PIC_WB_IDX_FLAGS)
      flags_q <= (flags_q & ~wdata[6:0]) | evt;
    else
      flags_q <= flags_q | evt;
  end

  // Indirect read mux
  always_comb
  begin
    unique case (index_q)
      `PIC_WB_IDX_ENABLE: val_rd = enable_q;
      `PIC_WB_IDX_FLAGS: val_rd = {1'b0, flags_q};
      default: val_rd = 8'h00;
    endcase
  end

  assign wb_enable = enable_q[`PIC_WB_GIE_BIT];
  assign request = wb_enable && |(flags_q & enable_q[6:0]);
endmodule : pic_wirebus_irq

// ### verilog/pic_top.sv
// Priority interrupt controller top: sixteen sources, three levels,
// vectoring, auto-clear on entry, register port and event interrupt.
// Assumes a CPU core that acknowledges vectors and signals returns.
//
// Summary of operation
// - Sixteen sources, three priority levels arbitrated
// - Maskable source needs own and global enable
// - Global enable clear blocks all maskables
// - Power-fail alone at top, no global gate
// - Priority bit one means high priority
// - Ties go to lowest natural number
// - Ext two-five and bus master share vector
// - Bus master enable overrides ext five
// - Timer zero/one flags clear on entry
// - Edge ext0/ext1 flags clear on entry
// - Level ext0/ext1 flags follow pin
// - Bus master enables reached indirectly only
// - Bus master flags reached indirectly only
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_top
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Ext0/ext1 pins (active high request level) and group pins 2..5
  input wire logic EXT0_PIN,
  input wire logic EXT1_PIN,
  input wire logic [3:0] EXT_GROUP_PIN,
  // Peripheral event pulses; index = natural priority, 0 is power-fail
  input wire pic_pkg::pic_src_t SRC_EVENT,
  // Wire bus master events
  input wire logic [6:0] WIREBUS_EVENT,
  // CPU handshake
  input wire logic CPU_ACK,
  input wire logic CPU_RETI,
  output logic CPU_IRQ,
  output pic_pkg::pic_vec_t CPU_VECTOR,
  output pic_pkg::pic_level_e CPU_LEVEL,
  // Event interrupt
  output logic IRQ
);
  import pic_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] enable_q; // Per-source enables, bit 0 unused
  logic [15:0] prio_q; // Per-source priority bits, bit 0 unused
  logic [3:0] ctrl_q; // Global, power-fail enable, edge modes
  logic [15:0] flag_q; // Latched request flags
  logic [2:0] evt_q; // Sticky events: grant, preempt, return
  logic [2:0] evt_mask_q; // Event mask
  logic [2:0] stack_q; // In-service levels: low, high, top
  logic ext0_pin_q; // Previous pin levels for edge detect
  logic ext1_pin_q;
  logic [3:0] grp_pin_q;
  logic [3:0] grp_flag_q; // Flags for ext2..ext5
  logic [7:0] rdata_q;
  logic irq_q;
  logic cpu_irq_q;
  pic_vec_t vector_q;
  pic_level_e level_q;
  logic [3:0] grant_src_q; // Source number of the granted request

  // Wire bus master links
  logic wb_request;
  logic wb_enable;
  logic [7:0] wb_rd;
  logic wb_idx_wr;
  logic wb_val_wr;

  assign wb_idx_wr = WR && ADDR == `PIC_OFS_WB_INDEX;
  assign wb_val_wr = WR && ADDR == `PIC_OFS_WB_VALUE;

  pic_wirebus_irq u_wirebus
  (
    .clk(CLK),
    .reset_n(RESET_N),
    .evt(WIREBUS_EVENT),
    .idx_wr(wb_idx_wr),
    .val_wr(wb_val_wr),
    .wdata(WDATA),
    .val_rd(wb_rd),
    .request(wb_request),
    .wb_enable(wb_enable)
  );

  // ----------------------------------------------------------------
  // Control registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      enable_q <= 16'h0000;
      prio_q <= 16'h0000;
      ctrl_q <= 4'h0;
      evt_mask_q <= 3'h0;
    end
    else if (WR)
    begin
      unique case (ADDR)
        `PIC_OFS_ENABLE_LO: enable_q[7:0] <= WDATA;
        `PIC_OFS_ENABLE_HI: enable_q[15:8] <= WDATA;
        `PIC_OFS_PRIO_LO: prio_q[7:0] <= WDATA;
        `PIC_OFS_PRIO_HI: prio_q[15:8] <= WDATA;
        `PIC_OFS_CTRL: ctrl_q <= WDATA[3:0];
        `PIC_OFS_EVT_MASK: evt_mask_q <= WDATA[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Group sources 2..5: latched on rising pin, write one to clear
  // ----------------------------------------------------------------
  logic [3:0] grp_rise;
  assign grp_rise = EXT_GROUP_PIN & ~grp_pin_q;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      grp_pin_q <= 4'h0;
      grp_flag_q <= 4'h0;
    end
    else
    begin
      grp_pin_q <= EXT_GROUP_PIN;
      if (WR && ADDR == `PIC_OFS_STATUS)
        grp_flag_q <= (grp_flag_q & ~WDATA[7:4]) | grp_rise;
      else
        grp_flag_q <= grp_flag_q | grp_rise;
    end
  end

  // Merged ext5/bus master line, bus master wins when enabled
  logic ext5_line;
  assign ext5_line = wb_enable ? wb_request : grp_flag_q[3];
  logic group_req;
  assign group_req = |grp_flag_q[2:0] | ext5_line;

  // ----------------------------------------------------------------
  // Source flags: set wins, software clear, hardware clear on entry for timers and edge ext0/ext1
  // ----------------------------------------------------------------
  logic ext0_set;
  logic ext1_set;
  logic entry;
  assign ext0_set = ctrl_q[`PIC_CTRL_IT0] ? (EXT0_PIN && !ext0_pin_q) : 1'b0;
  assign ext1_set = ctrl_q[`PIC_CTRL_IT1] ? (EXT1_PIN && !ext1_pin_q) : 1'b0;
  assign entry = CPU_ACK && cpu_irq_q;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ext0_pin_q <= 1'b0;
      ext1_pin_q <= 1'b0;
    end
    else
    begin
      ext0_pin_q <= EXT0_PIN;
      ext1_pin_q <= EXT1_PIN;
    end
  end

  // Flag array, one generate entry per source
  logic [15:0] sw_clr;
  assign sw_clr = {(WR && ADDR == `PIC_OFS_FLAG_HI) ? WDATA : 8'h00,
                   (WR && ADDR == `PIC_OFS_FLAG_LO) ? WDATA : 8'h00};

  for (genvar i = 0; i < 16; i++)
  begin : g_flag
    logic set_i;
    logic hw_clr_i;
    if (i == `PIC_SRC_EXT0)
    begin : g_e0
      assign set_i = ext0_set | SRC_EVENT[i];
      assign hw_clr_i = entry && grant_src_q == 4'(i) && ctrl_q[`PIC_CTRL_IT0];
    end
    else if (i == `PIC_SRC_EXT1)
    begin : g_e1
      assign set_i = ext1_set | SRC_EVENT[i];
      assign hw_clr_i = entry && grant_src_q == 4'(i) && ctrl_q[`PIC_CTRL_IT1];
    end
    else if (i == `PIC_SRC_TMR0 || i == `PIC_SRC_TMR1)
    begin : g_tm
      assign set_i = SRC_EVENT[i];
      assign hw_clr_i = entry && grant_src_q == 4'(i);
    end
    else
    begin : g_sw
      assign set_i = SRC_EVENT[i];
      assign hw_clr_i = 1'b0;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
      if (!RESET_N)
        flag_q[i] <= 1'b0;
      else if (set_i)
        flag_q[i] <= 1'b1;
      else if (sw_clr[i] || hw_clr_i)
        flag_q[i] <= 1'b0;
    end
  end

  // Effective request vector; level-mode ext0/ext1 follow the pin
  logic [15:0] req;
  always_comb
  begin
    req = flag_q;
    req[`PIC_SRC_EXT0] = ctrl_q[`PIC_CTRL_IT0] ? flag_q[`PIC_SRC_EXT0] : EXT0_PIN;
    req[`PIC_SRC_EXT1] = ctrl_q[`PIC_CTRL_IT1] ? flag_q[`PIC_SRC_EXT1] : EXT1_PIN;
    req[`PIC_SRC_GRP] = group_req;
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [15:0] live;
  logic [15:0] hi_set;
  logic [15:0] lo_set;
  logic pf_live;
  assign pf_live = req[`PIC_SRC_PF] && ctrl_q[`PIC_CTRL_PFE];
  assign live = req & enable_q & {16{ctrl_q[`PIC_CTRL_GIE]}};
  assign hi_set = live & prio_q & 16'hFFFE;
  assign lo_set = live & ~prio_q & 16'hFFFE;

  // Lowest set index wins
  function automatic logic [3:0] pic_first(input logic [15:0] v);
    pic_first = 4'h0;
    for (int k = 15; k >= 0; k--)
      if (v[k])
        pic_first = 4'(k);
  endfunction : pic_first

  // Fixed vector table
  function automatic pic_vec_t pic_vector(input logic [3:0] s);
    pic_vec_t t [16] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B,
                         8'h43, 8'h4B, 8'h53, 8'h5B, 8'h6B, 8'h73, 8'h63, 8'h7B};
    pic_vector = t[s];
  endfunction : pic_vector

  logic cand_valid;
  logic [3:0] cand_src;
  pic_level_e cand_lvl;
  always_comb
  begin
    cand_valid = 1'b0;
    cand_src = 4'h0;
    cand_lvl = PIC_LVL_NONE;
    if (pf_live && !stack_q[2])
    begin
      cand_valid = 1'b1;
      cand_lvl = PIC_LVL_TOP;
    end
    else if (|hi_set && stack_q[2:1] == 2'b00)
    begin
      cand_valid = 1'b1;
      cand_src = pic_first(hi_set);
      cand_lvl = PIC_LVL_HIGH;
    end
    else if (|lo_set && stack_q == 3'b000)
    begin
      cand_valid = 1'b1;
      cand_src = pic_first(lo_set);
      cand_lvl = PIC_LVL_LOW;
    end
  end

  // Request to CPU, held until acknowledged
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cpu_irq_q <= 1'b0;
      vector_q <= `PIC_RST_VEC;
      level_q <= PIC_LVL_NONE;
      grant_src_q <= 4'h0;
    end
    else if (entry)
      cpu_irq_q <= 1'b0;
    else if (!cpu_irq_q && cand_valid)
    begin
      cpu_irq_q <= 1'b1;
      vector_q <= pic_vector(cand_src);
      level_q <= cand_lvl;
      grant_src_q <= cand_src;
    end
  end

  // In-service levels; return retires the highest
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      stack_q <= 3'b000;
    else if (entry)
      stack_q[level_q - 2'd1] <= 1'b1;
    else if (CPU_RETI)
    begin
      if (stack_q[2])
        stack_q[2] <= 1'b0;
      else if (stack_q[1])
        stack_q[1] <= 1'b0;
      else
        stack_q[0] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Events: grant, preemption, return; read clears, set wins
  // ----------------------------------------------------------------
  logic [2:0] evt_set;
  assign evt_set = {CPU_RETI, entry && |stack_q, entry};

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      evt_q <= 3'h0;
    else if (RD && ADDR == `PIC_OFS_EVT)
      evt_q <= evt_set;
    else
      evt_q <= evt_q | evt_set;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_q <= 1'b0;
    else
      irq_q <= |(evt_q & evt_mask_q);
  end

  // ----------------------------------------------------------------
  // Read data, valid the cycle after RD
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rdata_q <= 8'h00;
    else if (RD)
    begin
      unique case (ADDR)
        `PIC_OFS_ENABLE_LO: rdata_q <= enable_q[7:0];
        `PIC_OFS_ENABLE_HI: rdata_q <= enable_q[15:8];
        `PIC_OFS_PRIO_LO: rdata_q <= prio_q[7:0];
        `PIC_OFS_PRIO_HI: rdata_q <= prio_q[15:8];
        `PIC_OFS_CTRL: rdata_q <= {4'h0, ctrl_q};
        `PIC_OFS_FLAG_LO: rdata_q <= req[7:0];
        `PIC_OFS_FLAG_HI: rdata_q <= req[15:8];
        `PIC_OFS_STATUS: rdata_q <= {grp_flag_q, 1'b0, stack_q};
        `PIC_OFS_EVT: rdata_q <= {5'h00, evt_q};
        `PIC_OFS_EVT_MASK: rdata_q <= {5'h00, evt_mask_q};
        `PIC_OFS_WB_VALUE: rdata_q <= wb_rd;
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign CPU_IRQ = cpu_irq_q;
  assign CPU_VECTOR = vector_q;
  assign CPU_LEVEL = level_q;
endmodule : pic_top

// ### verif/pic_top_properties.sv
// Port checker for the interrupt controller top.
// Assumes one clock domain and binding onto pic_top.
`timescale 1ns/100ps
module pic_top_properties
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // CPU link
  input wire logic CPU_ACK,
  input wire logic CPU_IRQ,
  input wire pic_pkg::pic_vec_t CPU_VECTOR,
  input wire pic_pkg::pic_level_e CPU_LEVEL
);
  import pic_pkg::*;
  // ----------------------------------------
  // Shared clocking and sequences
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // Request shown, not yet taken
  sequence s_offer;
    CPU_IRQ && !CPU_ACK;
  endsequence
  // Request taken by the core
  sequence s_take;
    CPU_IRQ && CPU_ACK;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  chk_unmapped_read: assert property (RD && ADDR > 8'h0B |=> RDATA == 8'h00)
    else $error("unmapped read returned data");
  chk_offer_holds: assert property (s_offer |=> CPU_IRQ)
    else $error("request withdrawn before acknowledge");
  chk_offer_stable: assert property (s_offer |=> $stable(CPU_VECTOR) && $stable(CPU_LEVEL))
    else $error("vector or level moved while offered");
  chk_ack_drops: assert property (s_take |=> !CPU_IRQ)
    else $error("request still up after acknowledge");
  chk_vector_legal: assert property (CPU_IRQ |-> CPU_VECTOR inside {8'h03, 8'h0B, 8'h13,
    8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63, 8'h6B, 8'h73, 8'h7B})
    else $error("vector not in the fixed table");
  chk_top_vector: assert property (CPU_IRQ |-> (CPU_VECTOR == 8'h33) == (CPU_LEVEL == PIC_LVL_TOP))
    else $error("top level and power-fail vector disagree");
  chk_level_set: assert property (CPU_IRQ |-> CPU_LEVEL != PIC_LVL_NONE)
    else $error("request offered with no level");
endmodule : pic_top_properties

bind pic_top pic_top_properties u_chk (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .RD(RD),
  .RDATA(RDATA), .CPU_ACK(CPU_ACK), .CPU_IRQ(CPU_IRQ), .CPU_VECTOR(CPU_VECTOR),
  .CPU_LEVEL(CPU_LEVEL));

// ### verif/pic_cpu_model.sv
// Core model: takes vectors after a set wait and returns on request.
// Assumes the bench pulses reti_req for one cycle.
`timescale 1ns/100ps
module pic_cpu_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Controller side
  input wire logic cpu_irq,
  input wire pic_pkg::pic_vec_t cpu_vector,
  input wire pic_pkg::pic_level_e cpu_level,
  output logic cpu_ack,
  output logic cpu_reti,
  // Bench side
  input wire logic [3:0] ack_wait,
  input wire logic reti_req,
  output pic_pkg::pic_vec_t vec_tk,
  output pic_pkg::pic_level_e lvl_tk,
  output logic [7:0] ack_cnt
);
  import pic_pkg::*;
  logic [3:0] wait_q; // Cycles the offer has stood
  logic [3:0] depth_q; // Routines entered, not returned
  // Acknowledge after the wait, latch what was taken
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
      ack_cnt <= 8'h00;
      vec_tk <= 8'h00;
      lvl_tk <= PIC_LVL_NONE;
    end
    else
    begin
      cpu_ack <= 1'b0;
      if (cpu_irq && !cpu_ack && wait_q == ack_wait)
      begin
        cpu_ack <= 1'b1;
        wait_q <= 4'h0;
        ack_cnt <= ack_cnt + 8'h01;
        vec_tk <= cpu_vector;
        lvl_tk <= cpu_level;
      end
      else if (cpu_irq && !cpu_ack)
        wait_q <= wait_q + 4'h1;
    end
  end
  // Return only from a routine that was entered
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_reti <= 1'b0;
      depth_q <= 4'h0;
    end
    else
    begin
      cpu_reti <= reti_req && depth_q != 4'h0;
      depth_q <= depth_q + {3'h0, cpu_ack} - {3'h0, reti_req && depth_q != 4'h0};
    end
  end
endmodule : pic_cpu_model

// ### verif/priority_interrupt_controller_tb_top.sv
// Self-checking bench for pic_top with a core model.
// Assumes pic_top, pic_cpu_model and the checker are compiled first.
`timescale 1ns/100ps
`include "pic_defines.svh"
module priority_interrupt_controller_tb_top;
  import pic_pkg::*;
  // One source case: number, control, priority bit, vector, flag after entry
  typedef struct packed {int src; logic [7:0] ctl; logic pri; logic [7:0] vec; logic flg;} pic_row_s;
  logic clk, reset_n, wr, rd, ext0, ext1, ack, reti, irq, cirq, reti_req;
  logic [7:0] addr, wdata, rdata, ack_cnt, d, f;
  logic [3:0] grp, ack_wait;
  logic [6:0] wbev;
  pic_src_t src, m;
  pic_vec_t vec, vec_tk;
  pic_level_e lvl, lvl_tk;
  int err_count, num_checks;
  pic_row_s r;
  pic_row_s rows [17] = '{'{0, 8'h03, 0, 8'h33, 1}, '{1, 8'h03, 0, 8'h03, 1},
    '{1, 8'h07, 1, 8'h03, 0}, '{2, 8'h03, 1, 8'h0B, 0}, '{3, 8'h0B, 0, 8'h13, 0},
    '{4, 8'h03, 0, 8'h1B, 0}, '{5, 8'h03, 1, 8'h23, 1}, '{6, 8'h03, 0, 8'h2B, 1},
    '{7, 8'h03, 1, 8'h3B, 1}, '{8, 8'h03, 0, 8'h43, 1}, '{9, 8'h03, 1, 8'h4B, 1},
    '{10, 8'h03, 0, 8'h53, 1}, '{11, 8'h03, 1, 8'h5B, 1}, '{12, 8'h03, 0, 8'h6B, 1},
    '{13, 8'h03, 1, 8'h73, 1}, '{14, 8'h03, 0, 8'h63, 1}, '{15, 8'h03, 1, 8'h7B, 1}};
  // Design and core model
  pic_top u_dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXT0_PIN(ext0), .EXT1_PIN(ext1), .EXT_GROUP_PIN(grp), .SRC_EVENT(src),
    .WIREBUS_EVENT(wbev), .CPU_ACK(ack), .CPU_RETI(reti), .CPU_IRQ(cirq), .CPU_VECTOR(vec),
    .CPU_LEVEL(lvl), .IRQ(irq));
  pic_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .cpu_irq(cirq), .cpu_vector(vec),
    .cpu_level(lvl), .cpu_ack(ack), .cpu_reti(reti), .ack_wait(ack_wait), .reti_req(reti_req),
    .vec_tk(vec_tk), .lvl_tk(lvl_tk), .ack_cnt(ack_cnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #10 v = rdata;
  endtask : rd_reg
  // Pins for ext0, ext1 and group take the request, the rest pulse
  task pulse(input pic_src_t p);
    @(posedge clk);
    ext0 <= ext0 | p[1];
    ext1 <= ext1 | p[3];
    grp[0] <= grp[0] | p[8];
    src <= p & 16'hFEF5;
    @(posedge clk);
    src <= 16'h0000;
  endtask : pulse
  // Wait for the core to take a vector, then check it
  task take(input logic [7:0] v, input logic [7:0] l);
    logic [7:0] n;
    n = ack_cnt;
    repeat (30) if (ack_cnt === n) @(posedge clk) #1;
    cmp({7'h0, ack_cnt !== n}, 8'h01);
    cmp(vec_tk, v);
    cmp({6'h0, lvl_tk}, l);
  endtask : take
  task quiet();
    repeat (6) @(posedge clk);
    #1 cmp({7'h0, cirq}, 8'h00);
  endtask : quiet
  task ret();
    @(posedge clk);
    reti_req <= 1'b1;
    @(posedge clk);
    reti_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : ret
  task complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial
  begin
    {reset_n, wr, rd, ext0, ext1, reti_req, addr, wdata, grp, wbev, src, ack_wait} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(`PIC_OFS_CTRL, d);
    cmp(d, `PIC_RST_BYTE);
    wr_reg(8'h20, 8'hFF);
    rd_reg(8'h20, d);
    cmp(d, 8'h00);
    wr_reg(`PIC_OFS_EVT_MASK, 8'h01);
    // Every source alone, one row each, two for ext0 in level and edge mode
    for (int i = 0; i < 17; i++)
    begin
      r = rows[i];
      m = 16'h0001 << r.src;
      ack_wait <= r.pri ? 4'h3 : 4'h0;
      wr_reg(`PIC_OFS_CTRL, r.ctl);
      wr_reg(`PIC_OFS_ENABLE_LO, m[7:0]);
      wr_reg(`PIC_OFS_ENABLE_HI, m[15:8]);
      wr_reg(`PIC_OFS_PRIO_LO, m[7:0] & {8{r.pri}});
      wr_reg(`PIC_OFS_PRIO_HI, m[15:8] & {8{r.pri}});
      pulse(m);
      take(r.vec, r.src == 0 ? PIC_LVL_TOP : r.pri ? PIC_LVL_HIGH : PIC_LVL_LOW);
      rd_reg(r.src < 8 ? `PIC_OFS_FLAG_LO : `PIC_OFS_FLAG_HI, f);
      cmp({7'h0, f[r.src % 8]}, {7'h0, r.flg});
      {ext0, ext1, grp} <= '0;
      wr_reg(`PIC_OFS_FLAG_LO, m[7:0]);
      wr_reg(`PIC_OFS_FLAG_HI, m[15:8]);
      wr_reg(`PIC_OFS_STATUS, 8'hF0);
      ret();
    end
    #1 cmp({7'h0, irq}, 8'h01);
    rd_reg(`PIC_OFS_EVT, d);
    cmp(d, 8'h05);
    repeat (2) @(posedge clk);
    #1 cmp({7'h0, irq}, 8'h00);
    $display("test source table done");
    // Ties, preemption and blocking at the same level
    ack_wait <= 4'h0;
    wr_reg(`PIC_OFS_EVT_MASK, 8'h00);
    wr_reg(`PIC_OFS_ENABLE_LO, 8'hE0);
    wr_reg(`PIC_OFS_ENABLE_HI, 8'h02);
    wr_reg(`PIC_OFS_PRIO_LO, 8'h20);
    wr_reg(`PIC_OFS_PRIO_HI, 8'h00);
    pulse(16'h00C0);
    take(8'h2B, PIC_LVL_LOW);
    pulse(16'h0020);
    take(8'h23, PIC_LVL_HIGH);
    rd_reg(`PIC_OFS_STATUS, d);
    cmp(d, 8'h03);
    pulse(16'h0200);
    quiet();
    wr_reg(`PIC_OFS_FLAG_LO, 8'hE0);
    ret();
    quiet();
    ret();
    take(8'h4B, PIC_LVL_LOW);
    wr_reg(`PIC_OFS_FLAG_HI, 8'h02);
    ret();
    rd_reg(`PIC_OFS_EVT, d);
    cmp(d, 8'h07);
    cmp({7'h0, irq}, 8'h00);
    $display("test nesting done");
    // Global enable gates maskable sources
    wr_reg(`PIC_OFS_ENABLE_LO, 8'h04);
    wr_reg(`PIC_OFS_ENABLE_HI, 8'h00);
    wr_reg(`PIC_OFS_CTRL, 8'h02);
    pulse(16'h0004);
    quiet();
    wr_reg(`PIC_OFS_CTRL, 8'h03);
    take(8'h0B, PIC_LVL_LOW);
    ret();
    ext0 <= 1'b1;
    rd_reg(`PIC_OFS_FLAG_LO, f);
    cmp(f & 8'h02, 8'h02);
    @(posedge clk);
    ext0 <= 1'b0;
    rd_reg(`PIC_OFS_FLAG_LO, f);
    cmp(f & 8'h02, 8'h00);
    $display("test global enable done");
    // Bus master request through the shared vector
    wr_reg(`PIC_OFS_ENABLE_LO, 8'h00);
    wr_reg(`PIC_OFS_ENABLE_HI, 8'h01);
    wr_reg(`PIC_OFS_WB_INDEX, {5'h0, `PIC_WB_IDX_ENABLE});
    wr_reg(`PIC_OFS_WB_VALUE, 8'h81);
    @(posedge clk);
    wbev <= 7'h01;
    @(posedge clk);
    wbev <= 7'h00;
    take(8'h43, PIC_LVL_LOW);
    wr_reg(`PIC_OFS_WB_INDEX, {5'h0, `PIC_WB_IDX_FLAGS});
    rd_reg(`PIC_OFS_WB_VALUE, d);
    cmp(d, 8'h01);
    wr_reg(`PIC_OFS_WB_VALUE, 8'h01);
    rd_reg(`PIC_OFS_WB_VALUE, d);
    cmp(d, 8'h00);
    wr_reg(`PIC_OFS_WB_INDEX, {5'h0, `PIC_WB_IDX_ENABLE});
    ret();
    // Ext5 pin is shut out while the bus master enable stands
    grp <= 4'h8;
    quiet();
    wr_reg(`PIC_OFS_WB_VALUE, 8'h00);
    take(8'h43, PIC_LVL_LOW);
    wr_reg(`PIC_OFS_STATUS, 8'hF0);
    grp <= 4'h0;
    ret();
    $display("test bus master done");
    // Second reset in mid-run restores the control byte
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(`PIC_OFS_CTRL, d);
    cmp(d, `PIC_RST_BYTE);
    $display("test reset done");
    complete_run();
  end
endmodule : priority_interrupt_controller_tb_top
